// ### usbev_regs.svh
// constants for the usb device event flags, transfer irq enables, pad trim and endpoint status update
// assumes the includer uses byte-wide i/o register offsets relative to the module base
// What this block does
// - transaction-done irq raised only with its enable set and level nonzero
// - setup-done irq raised only with its enable set and level nonzero
// - each flag register has set and clear addresses; writing zero does nothing
// - frame-start flag, bit 7 of register A, set on each start-of-frame packet
// - bus idle flag set after bus idle for 3 ms
// - wake flag set on non-idle bus while suspended, detected without clock
// - bus reset flag set when reset seen on the lines
// - iso checksum error flag set on iso data packet crc failure
// - global underrun flag set when IN endpoint has no data
// - global overrun flag set when OUT endpoint cannot accept data
// - global halt flag set when IN or OUT answered with STALL
// - transaction-done flag follows pending fifo entry; setup-done set on good SETUP
// - 16 endpoint addresses; OUT at pointer+16*addr, IN eight bytes later
// - endpoint bit 7 set on STALL, or iso OUT crc error; write one clears
// - endpoint bit 6 set when endpoint cannot supply or accept data
// - bit 5 on good IN/OUT, bit 4 on good SETUP/IN/OUT; write one clears
// - bit 3 toggles per good transaction with ping-pong; write one clears
// - refuse flags bits 1 and 2 discard data and answer NAK except iso
// - bit 0 selects data pid; iso accepts both and sends DATA0
// - kind field decodes disabled, control, bulk/interrupt, iso; disabled gets no access after its control byte read
// - multipacket enable moves large payloads as many packets silently
// - zero irq level disables all module interrupts, nonzero selects priority
`ifndef USBEV_REGS_SVH
`define USBEV_REGS_SVH

// ************************************
// register offsets
// ************************************
`define USBEV_OFS_IRQ_CTRL_A   8'h06
`define USBEV_OFS_IRQ_CTRL_B   8'h07
`define USBEV_OFS_FLAGS_A_CLR  8'h0A
`define USBEV_OFS_FLAGS_A_SET  8'h0B
`define USBEV_OFS_FLAGS_B_CLR  8'h0C
`define USBEV_OFS_FLAGS_B_SET  8'h0D
`define USBEV_OFS_TRIM_LOW     8'h3A
`define USBEV_OFS_TRIM_HIGH    8'h3B

// ************************************
// field positions
// ************************************
`define USBEV_FA_FRAME        7
`define USBEV_FA_IDLE         6
`define USBEV_FA_WAKE         5
`define USBEV_FA_RESET        4
`define USBEV_FA_CRC          3
`define USBEV_FA_UNDER        2
`define USBEV_FA_OVER         1
`define USBEV_FA_HALT         0
`define USBEV_FB_TRN          1
`define USBEV_FB_SETUP        0
`define USBEV_EP_HALT         7
`define USBEV_EP_UNOV         6
`define USBEV_EP_DONE_A       5
`define USBEV_EP_DONE_B       4
`define USBEV_EP_BANK         3
`define USBEV_EP_REFUSE1      2
`define USBEV_EP_REFUSE0      1
`define USBEV_EP_TOGGLE       0
`define USBEV_CTRL_KIND_HI    7
`define USBEV_CTRL_KIND_LO    6
`define USBEV_CTRL_MULTI      5
`define USBEV_CTRL_PINGPONG   4

// ************************************
// reset values and geometry
// ************************************
`define USBEV_RST_BYTE        8'h00
`define USBEV_EP_STRIDE       16'h0010
`define USBEV_EP_IN_OFS       16'h0008

// ************************************
// timing
// ************************************
`define USBEV_CLK_MHZ         200
`define USBEV_IDLE_MS         3
`define USBEV_IDLE_CYCLES     (`USBEV_IDLE_MS * 1000 * `USBEV_CLK_MHZ)

`endif

// ### usbev_pkg.sv
// types shared by the usb event block
// assumes usbev_regs.svh supplies all numeric constants
package usbev_pkg;
	typedef enum logic [1:0] {
		USBEV_KIND_OFF  = 2'b00,
		USBEV_KIND_CTRL = 2'b01,
		USBEV_KIND_BULK = 2'b10,
		USBEV_KIND_ISO  = 2'b11
	} usbev_kind_t;

	typedef enum logic [1:0] {
		USBEV_TOK_OUT   = 2'b00,
		USBEV_TOK_IN    = 2'b01,
		USBEV_TOK_SETUP = 2'b10,
		USBEV_TOK_NONE  = 2'b11
	} usbev_tok_t;

	typedef enum logic [1:0] {
		USBEV_RES_ACK   = 2'b00,
		USBEV_RES_NAK   = 2'b01,
		USBEV_RES_STALL = 2'b10,
		USBEV_RES_CRC   = 2'b11
	} usbev_res_t;
endpackage : usbev_pkg

// ### usbev_core.sv
// usb device event flags, transfer irq enables, pad trim and endpoint status update
// assumes a byte i/o bus, a link engine that reports transaction results, and an sram port
`timescale 1ns/1ps
`include "usbev_regs.svh"

module usbev_core
	import usbev_pkg::*;
#(
	parameter int unsigned IDLE_CYCLES = `USBEV_IDLE_CYCLES
) (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// i/o register port
	input  wire logic [7:0]  ioAddr,
	input  wire logic        ioWrite,
	input  wire logic        ioRead,
	input  wire logic [7:0]  ioWdata,
	output logic      [7:0]  ioRdata,
	// bus line state from the receiver
	input  wire logic        lineIdle,
	input  wire logic        lineSe0Reset,
	input  wire logic        sofSeen,
	input  wire logic        fifoPending,
	// transaction report from the link engine
	input  wire logic        trnValid,
	input  wire logic [1:0]  trnToken,
	input  wire logic [1:0]  trnResult,
	input  wire logic [3:0]  trnEpAddr,
	input  wire logic [15:0] endpointTablePointer,
	// sram port for endpoint bytes
	output logic             sramRead,
	output logic             sramWrite,
	output logic      [15:0] sramAddr,
	output logic      [7:0]  sramWdata,
	input  wire logic [7:0]  sramRdata,
	input  wire logic        sramAck,
	// decisions back to the link engine
	output logic             epReplyValid,
	output logic             epReplyNak,
	output logic             epDataPid,
	output logic             epMultiPacket,
	// interrupt and trim outputs
	output logic             busIrq,
	output logic             transferIrq,
	output logic      [1:0]  irqPriorityLevel,
	output logic      [15:0] padTrim,
	output logic             suspended
);

	// ************************************
	// pin synchronisers
	// ************************************
	// only the last two stages are compared
	logic [2:0] idleSync_reg;
	logic [2:0] rstSync_reg;
	logic       idleSeen_reg;
	logic       rstSeen_reg;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			idleSync_reg <= 3'h0;
			rstSync_reg  <= 3'h0;
			idleSeen_reg <= 1'b0;
			rstSeen_reg  <= 1'b0;
		end else begin
			idleSync_reg <= {idleSync_reg[1:0], lineIdle};
			rstSync_reg  <= {rstSync_reg[1:0], lineSe0Reset};
			if (idleSync_reg[1] == idleSync_reg[2])
				idleSeen_reg <= idleSync_reg[2];
			if (rstSync_reg[1] == rstSync_reg[2])
				rstSeen_reg <= rstSync_reg[2];
		end
	end

	// wake is latched without the clock so a stopped clock still sees it
	logic wakeAsync_reg;
	logic wakeClr;
	logic [2:0] wakeSync_reg;
	logic       wakeSeen_reg;
	logic       suspended_reg;

	always_ff @(negedge lineIdle or posedge wakeClr) begin
		if (wakeClr)
			wakeAsync_reg <= 1'b0;
		else
			wakeAsync_reg <= suspended_reg;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wakeSync_reg <= 3'h0;
			wakeSeen_reg <= 1'b0;
		end else begin
			wakeSync_reg <= {wakeSync_reg[1:0], wakeAsync_reg};
			if (wakeSync_reg[1] == wakeSync_reg[2])
				wakeSeen_reg <= wakeSync_reg[2];
		end
	end

	// ************************************
	// idle timer
	// ************************************
	// parks at the top, so one flag per idle stretch
	logic [31:0] idleCnt_reg;
	wire         idleExpire = idleSeen_reg && (idleCnt_reg == IDLE_CYCLES - 1);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			idleCnt_reg   <= 32'h0000_0000;
			suspended_reg <= 1'b0;
		end else begin
			if (!idleSeen_reg)
				idleCnt_reg <= 32'h0000_0000;
			else if (!idleExpire && !suspended_reg)
				idleCnt_reg <= idleCnt_reg + 32'h0000_0001;
			if (idleExpire && !suspended_reg)
				suspended_reg <= 1'b1;
			else if (!idleSeen_reg)
				suspended_reg <= 1'b0;
		end
	end

	// async clear only after the synced copy has landed, or while reset is held
	assign wakeClr = !rst_n || wakeSeen_reg;

	// ************************************
	// register decode
	// ************************************
	wire selCtrlA = ioAddr == `USBEV_OFS_IRQ_CTRL_A;
	wire selCtrlB = ioAddr == `USBEV_OFS_IRQ_CTRL_B;
	wire selAClr  = ioAddr == `USBEV_OFS_FLAGS_A_CLR;
	wire selASet  = ioAddr == `USBEV_OFS_FLAGS_A_SET;
	wire selBClr  = ioAddr == `USBEV_OFS_FLAGS_B_CLR;
	wire selBSet  = ioAddr == `USBEV_OFS_FLAGS_B_SET;
	wire selTrimL = ioAddr == `USBEV_OFS_TRIM_LOW;
	wire selTrimH = ioAddr == `USBEV_OFS_TRIM_HIGH;

	logic [7:0] irqCtrlA_reg;
	logic [1:0] transferIrqEnables_reg;
	logic [7:0] flagsA_reg;
	logic [1:0] flagsB_reg;
	logic [15:0] padTrim_reg;

	// ************************************
	// hardware event sources
	// ************************************
	logic rstPrev_reg;
	logic wakePrev_reg;
	logic trnPrev_reg;
	// held copy of the accepted report, loaded below
	usbev_tok_t  tokHeld;
	usbev_res_t  resHeld;
	usbev_kind_t kindHeld;
	usbev_tok_t tok;
	usbev_res_t res;
	assign tok = usbev_tok_t'(trnToken);
	assign res = usbev_res_t'(trnResult);

	// global flags follow the reply pulse once per walk
	wire repDone = epReplyValid;
	wire evUnder = repDone && tokHeld == USBEV_TOK_IN && resHeld == USBEV_RES_NAK;
	wire evOver  = repDone && tokHeld == USBEV_TOK_OUT && resHeld == USBEV_RES_NAK;
	wire evHalt  = repDone && tokHeld != USBEV_TOK_SETUP && resHeld == USBEV_RES_STALL;
	wire evCrc   = repDone && tokHeld == USBEV_TOK_OUT && resHeld == USBEV_RES_CRC && kindHeld == USBEV_KIND_ISO;
	wire evSetup = repDone && tokHeld == USBEV_TOK_SETUP && resHeld == USBEV_RES_ACK;

	wire [7:0] hwSetA = {sofSeen,
		idleExpire && !suspended_reg,
		wakeSeen_reg && !wakePrev_reg,
		rstSeen_reg && !rstPrev_reg,
		evCrc,
		evUnder,
		evOver,
		evHalt};
	wire [1:0] hwSetB = {fifoPending && !trnPrev_reg, evSetup};

	wire [7:0] swSetA = (ioWrite && selASet) ? ioWdata : 8'h00;
	wire [7:0] swClrA = (ioWrite && selAClr) ? ioWdata : 8'h00;
	wire [1:0] swSetB = (ioWrite && selBSet) ? ioWdata[1:0] : 2'h0;
	wire [1:0] swClrB = (ioWrite && selBClr) ? ioWdata[1:0] : 2'h0;

	// set terms after the clear mask: an event beats a clear
	wire [7:0] flagsA_next = (flagsA_reg & ~swClrA) | swSetA | hwSetA;
	wire [1:0] flagsB_next = (flagsB_reg & ~swClrB) | swSetB | hwSetB;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			flagsA_reg   <= `USBEV_RST_BYTE;
			flagsB_reg   <= 2'h0;
			rstPrev_reg  <= 1'b0;
			wakePrev_reg <= 1'b0;
			trnPrev_reg  <= 1'b0;
		end else begin
			flagsA_reg   <= flagsA_next;
			flagsB_reg   <= flagsB_next;
			rstPrev_reg  <= rstSeen_reg;
			wakePrev_reg <= wakeSeen_reg;
			trnPrev_reg  <= fifoPending;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			irqCtrlA_reg           <= `USBEV_RST_BYTE;
			transferIrqEnables_reg <= 2'h0;
			padTrim_reg            <= 16'h0000;
		end else begin
			if (ioWrite && selCtrlA)
				irqCtrlA_reg <= ioWdata & 8'hF3;
			if (ioWrite && selCtrlB)
				transferIrqEnables_reg <= ioWdata[1:0];
			if (ioWrite && selTrimL)
				padTrim_reg[7:0] <= ioWdata;
			if (ioWrite && selTrimH)
				padTrim_reg[15:8] <= ioWdata;
		end
	end

	// ************************************
	// read mux and irq gating
	// ************************************
	// both addresses of a flag pair read one register
	wire [7:0] rdMux = selCtrlA ? irqCtrlA_reg :
		selCtrlB ? {6'h00, transferIrqEnables_reg} :
		(selAClr || selASet) ? flagsA_reg :
		(selBClr || selBSet) ? {6'h00, flagsB_reg} :
		selTrimL ? padTrim_reg[7:0] :
		selTrimH ? padTrim_reg[15:8] : 8'h00;

	// enables alone never raise a line
	wire levelOn  = irqCtrlA_reg[1:0] != 2'b00;
	wire busEvIrq = levelOn && ((irqCtrlA_reg[7] && flagsA_reg[`USBEV_FA_FRAME]) ||
		(irqCtrlA_reg[6] && |flagsA_reg[6:4]) ||
		(irqCtrlA_reg[5] && |flagsA_reg[3:1]) ||
		(irqCtrlA_reg[4] && flagsA_reg[`USBEV_FA_HALT]));
	wire trnIrq   = levelOn && ((transferIrqEnables_reg[1] && flagsB_reg[`USBEV_FB_TRN]) ||
		(transferIrqEnables_reg[0] && flagsB_reg[`USBEV_FB_SETUP]));

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ioRdata          <= 8'h00;
			busIrq           <= 1'b0;
			transferIrq      <= 1'b0;
			irqPriorityLevel <= 2'h0;
			padTrim          <= 16'h0000;
			suspended        <= 1'b0;
		end else begin
			ioRdata          <= ioRead ? rdMux : 8'h00;
			busIrq           <= busEvIrq;
			transferIrq      <= trnIrq;
			irqPriorityLevel <= irqCtrlA_reg[1:0];
			padTrim          <= padTrim_reg;
			suspended        <= suspended_reg;
		end
	end

	// ************************************
	// endpoint status update sequencer
	// ************************************
	typedef enum logic [2:0] {
		USBEV_EP_IDLE  = 3'b000,
		USBEV_EP_RDCTL = 3'b001,
		USBEV_EP_RDST  = 3'b010,
		USBEV_EP_WRST  = 3'b011,
		USBEV_EP_REPLY = 3'b100
	} usbev_epstate_t;

	usbev_epstate_t epState_reg;
	usbev_epstate_t epState_next;
	logic [15:0] epBase_reg;
	logic [7:0]  ctrlByte_reg;
	logic [7:0]  statByte_reg;
	logic [1:0]  tokHeld_reg;
	logic [1:0]  resHeld_reg;
	assign tokHeld  = usbev_tok_t'(tokHeld_reg);
	assign resHeld  = usbev_res_t'(resHeld_reg);
	assign kindHeld = usbev_kind_t'(ctrlByte_reg[7:6]);

	// OUT at pointer + 16*addr, IN eight bytes above
	wire [15:0] epBase = endpointTablePointer + {8'h00, trnEpAddr, 4'h0} +
		((tok == USBEV_TOK_IN) ? `USBEV_EP_IN_OFS : 16'h0000);

	wire isIso     = kindHeld == USBEV_KIND_ISO;
	wire pingPong  = ctrlByte_reg[`USBEV_CTRL_PINGPONG];
	// bank bit counts only with ping-pong on
	wire bankSel   = pingPong & statByte_reg[`USBEV_EP_BANK];
	wire refused   = bankSel ? statByte_reg[`USBEV_EP_REFUSE1] : statByte_reg[`USBEV_EP_REFUSE0];
	wire goodTrn   = resHeld == USBEV_RES_ACK && !(refused && !isIso);
	wire isDataTok = tokHeld != USBEV_TOK_SETUP;

	// new status built from the byte just read
	logic [7:0] statNew;
	always_comb begin
		statNew = statByte_reg;
		if (resHeld == USBEV_RES_STALL || (resHeld == USBEV_RES_CRC && isIso))
			statNew[`USBEV_EP_HALT] = 1'b1;
		if (resHeld == USBEV_RES_NAK || (refused && isDataTok))
			statNew[`USBEV_EP_UNOV] = 1'b1;
		if (goodTrn && isDataTok)
			statNew[`USBEV_EP_DONE_A] = 1'b1;
		if (goodTrn)
			statNew[`USBEV_EP_DONE_B] = 1'b1;
		if (goodTrn && pingPong)
			statNew[`USBEV_EP_BANK] = ~statByte_reg[`USBEV_EP_BANK];
		if (goodTrn && !isIso)
			statNew[`USBEV_EP_TOGGLE] = ~statByte_reg[`USBEV_EP_TOGGLE];
	end

	// a disabled kind ends the walk after the control byte
	always_comb begin
		epState_next = epState_reg;
		unique case (epState_reg)
			USBEV_EP_IDLE:  if (trnValid && tok != USBEV_TOK_NONE)
				epState_next = USBEV_EP_RDCTL;
			USBEV_EP_RDCTL: if (sramAck)
				epState_next = (sramRdata[7:6] == 2'b00) ? USBEV_EP_IDLE : USBEV_EP_RDST;
			USBEV_EP_RDST:  if (sramAck)
				epState_next = USBEV_EP_WRST;
			USBEV_EP_WRST:  if (sramAck)
				epState_next = USBEV_EP_REPLY;
			USBEV_EP_REPLY: epState_next = USBEV_EP_IDLE;
			default:        epState_next = USBEV_EP_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			epState_reg  <= USBEV_EP_IDLE;
			epBase_reg   <= 16'h0000;
			ctrlByte_reg <= 8'h00;
			statByte_reg <= 8'h00;
			tokHeld_reg  <= 2'h3;
			resHeld_reg  <= 2'h0;
		end else begin
			epState_reg <= epState_next;
			if (epState_reg == USBEV_EP_IDLE && trnValid) begin
				epBase_reg  <= epBase;
				tokHeld_reg <= trnToken;
				resHeld_reg <= trnResult;
			end
			if (epState_reg == USBEV_EP_RDCTL && sramAck)
				ctrlByte_reg <= sramRdata;
			if (epState_reg == USBEV_EP_RDST && sramAck)
				statByte_reg <= sramRdata;
		end
	end

	// sram strobes and replies are registered
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sramRead      <= 1'b0;
			sramWrite     <= 1'b0;
			sramAddr      <= 16'h0000;
			sramWdata     <= 8'h00;
			epReplyValid  <= 1'b0;
			epReplyNak    <= 1'b0;
			epDataPid     <= 1'b0;
			epMultiPacket <= 1'b0;
		end else begin
			sramRead  <= (epState_next == USBEV_EP_RDCTL || epState_next == USBEV_EP_RDST) && !sramAck;
			// write starts a cycle late so the data is settled while held
			sramWrite <= epState_reg == USBEV_EP_WRST && !sramAck;
			sramAddr  <= (epState_next == USBEV_EP_RDCTL) ? (epState_reg == USBEV_EP_IDLE ? epBase : epBase_reg) :
				epBase_reg + 16'h0001;
			sramWdata <= statNew;
			epReplyValid  <= epState_next == USBEV_EP_REPLY;
			epReplyNak    <= refused && !isIso;
			// pid in force before this walk's flip
			epDataPid     <= isIso ? 1'b0 : statByte_reg[`USBEV_EP_TOGGLE];
			epMultiPacket <= ctrlByte_reg[`USBEV_CTRL_MULTI];
		end
	end

endmodule : usbev_core

// ### usbev_core_assertions.sv
// concurrent checks on the usb event block ports
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps
`include "usbev_regs.svh"
module usbev_core_assertions
	import usbev_pkg::*;
#(
	parameter int unsigned IDLE_CYCLES = `USBEV_IDLE_CYCLES
) (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic [7:0]  ioAddr,
	input wire logic        ioWrite,
	input wire logic        ioRead,
	input wire logic [7:0]  ioWdata,
	input wire logic [7:0]  ioRdata,
	input wire logic        trnValid,
	input wire logic [1:0]  trnToken,
	input wire logic [1:0]  trnResult,
	input wire logic [3:0]  trnEpAddr,
	input wire logic [15:0] endpointTablePointer,
	input wire logic        sramRead,
	input wire logic        sramWrite,
	input wire logic [15:0] sramAddr,
	input wire logic [7:0]  sramWdata,
	input wire logic [7:0]  sramRdata,
	input wire logic        sramAck,
	input wire logic        epReplyValid,
	input wire logic        busIrq,
	input wire logic        transferIrq,
	input wire logic [1:0]  irqPriorityLevel,
	input wire logic [15:0] padTrim
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// ****
	// transaction tracking
	// ****
	logic [1:0] phase;
	logic [1:0] resL;
	logic [1:0] tokL;
	logic [1:0] kindL;
	logic [7:0] stL;
	// phase 1 waits for the control byte, 2 for the status byte
	always_ff @(posedge core_clk) begin
		if (!rst_n) phase <= 2'd0;
		else if (trnValid) phase <= 2'd1;
		else if (sramAck && phase != 2'd0) phase <= (phase == 2'd3) ? 2'd0 : phase + 2'd1;
	end
	always_ff @(posedge core_clk) begin
		if (trnValid) resL <= trnResult;
		if (trnValid) tokL <= trnToken;
		if (sramAck && phase == 2'd1) kindL <= sramRdata[7:6];
		if (sramAck && phase == 2'd2) stL <= sramRdata;
	end
	a_trn_irq_gate: assert property ((irqPriorityLevel == 2'b00) [*2] |-> !transferIrq)
		else $error("transfer irq while level is zero");
	a_bus_irq_gate: assert property ((irqPriorityLevel == 2'b00) [*2] |-> !busIrq)
		else $error("bus irq while level is zero");
	a_read_idle_zero: assert property (!ioRead |=> ioRdata == 8'h00)
		else $error("read data not zero without read");
	a_table_base_addr: assert property (trnValid && !sramRead && !sramWrite |=> sramRead
		&& sramAddr == $past(endpointTablePointer) + {8'h00, $past(trnEpAddr), 4'h0}
		+ (($past(trnToken) == USBEV_TOK_IN) ? 16'h0008 : 16'h0000))
		else $error("wrong endpoint control address");
	a_disabled_quiet: assert property (phase == 2'd1 && sramAck && sramRdata[7:6] == 2'b00
		|=> (!sramRead && !sramWrite && !epReplyValid) [*4])
		else $error("disabled endpoint accessed");
	a_trim_high_write: assert property (ioWrite && ioAddr == `USBEV_OFS_TRIM_HIGH
		|-> ##2 padTrim[15:8] == $past(ioWdata, 2))
		else $error("trim high byte not stored");
	a_level_write: assert property (ioWrite && ioAddr == `USBEV_OFS_IRQ_CTRL_A
		|-> ##2 irqPriorityLevel == $past(ioWdata[1:0], 2))
		else $error("irq level not stored");
	a_halt_status: assert property (sramWrite && resL == USBEV_RES_STALL |-> sramWdata[7])
		else $error("halt bit missing after stall");
	a_unov_status: assert property (sramWrite && resL == USBEV_RES_NAK |-> sramWdata[6])
		else $error("underrun or overrun bit missing");
	a_done_status: assert property (sramWrite && resL == USBEV_RES_ACK && stL[2:1] == 2'b00
		|-> sramWdata[4] && (sramWdata[5] == (tokL != USBEV_TOK_SETUP)))
		else $error("done bits wrong after good transaction");
	a_toggle_flip: assert property (sramWrite && resL == USBEV_RES_ACK && stL[2:1] == 2'b00
		|-> sramWdata[0] == ((kindL == USBEV_KIND_ISO) ? stL[0] : ~stL[0]))
		else $error("data toggle wrong");
endmodule : usbev_core_assertions

bind usbev_core usbev_core_assertions #(.IDLE_CYCLES(IDLE_CYCLES)) u_chk (
	.core_clk(core_clk), .rst_n(rst_n), .ioAddr(ioAddr), .ioWrite(ioWrite), .ioRead(ioRead),
	.ioWdata(ioWdata), .ioRdata(ioRdata), .trnValid(trnValid), .trnToken(trnToken),
	.trnResult(trnResult), .trnEpAddr(trnEpAddr), .endpointTablePointer(endpointTablePointer),
	.sramRead(sramRead), .sramWrite(sramWrite), .sramAddr(sramAddr), .sramWdata(sramWdata),
	.sramRdata(sramRdata), .sramAck(sramAck), .epReplyValid(epReplyValid), .busIrq(busIrq),
	.transferIrq(transferIrq), .irqPriorityLevel(irqPriorityLevel), .padTrim(padTrim)
);

// ### usbev_sram_model.sv
// sram partner holding the endpoint configuration bytes
// assumes requests held until ack; slow adds three wait cycles
`timescale 1ns/1ps
module usbev_sram_model (
	input  wire logic        core_clk,
	input  wire logic        slow,
	input  wire logic        sramRead,
	input  wire logic        sramWrite,
	input  wire logic [15:0] sramAddr,
	input  wire logic [7:0]  sramWdata,
	output logic      [7:0]  sramRdata,
	output logic             sramAck
);
	logic [7:0] mem [256];
	logic [1:0] waitCnt;
	initial begin
		sramAck = 1'b0;
		sramRdata = 8'h00;
		waitCnt = 2'd0;
	end
	always @(posedge core_clk) begin
		sramAck <= 1'b0;
		// data outside the ack cycle is never the last value
		sramRdata <= ~sramRdata;
		if ((sramRead || sramWrite) && !sramAck) begin
			if (waitCnt < (slow ? 2'd3 : 2'd0)) begin
				waitCnt <= waitCnt + 2'd1;
			end else begin
				waitCnt <= 2'd0;
				sramAck <= 1'b1;
				if (sramRead) sramRdata <= mem[sramAddr[7:0]];
				if (sramWrite) mem[sramAddr[7:0]] <= sramWdata;
			end
		end
	end
endmodule : usbev_sram_model

// ### usbev_tb.sv
// self-checking bench: registers, line events, irq gating, endpoint updates
// assumes usbev_core, its package and the sram partner are compiled first
`timescale 1ns/1ps
`include "usbev_regs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin nMismatch++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb
	import usbev_pkg::*;
;
	logic        core_clk, rst_n, ioWrite, ioRead, lineIdle, lineSe0Reset, sofSeen, fifoPending;
	logic        trnValid, sramRead, sramWrite, sramAck, slow, seen;
	logic        epReplyValid, epReplyNak, epDataPid, epMultiPacket, busIrq, transferIrq, suspended;
	logic [7:0]  ioAddr, ioWdata, ioRdata, sramWdata, sramRdata, base;
	logic [1:0]  trnToken, trnResult, irqPriorityLevel;
	logic [3:0]  trnEpAddr;
	logic [15:0] sramAddr, padTrim;
	logic [49:0] r;
	int          nMismatch, comparisons;
	// ep, token, result, ctrl, status in, status out, flags a, flags b, nak, reply
	localparam logic [49:0] ROWS [10] = '{
		{4'h3, USBEV_TOK_OUT, USBEV_RES_ACK, 8'hA0, 8'h00, 8'h31, 8'h00, 8'h00, 2'b01},
		{4'h3, USBEV_TOK_IN, USBEV_RES_STALL, 8'h80, 8'h00, 8'h80, 8'h01, 8'h00, 2'b01},
		{4'h5, USBEV_TOK_IN, USBEV_RES_NAK, 8'h80, 8'h00, 8'h40, 8'h04, 8'h00, 2'b01},
		{4'h5, USBEV_TOK_OUT, USBEV_RES_NAK, 8'h80, 8'h01, 8'h41, 8'h02, 8'h00, 2'b01},
		{4'h0, USBEV_TOK_SETUP, USBEV_RES_ACK, 8'h40, 8'h00, 8'h11, 8'h00, 8'h01, 2'b01},
		{4'h2, USBEV_TOK_OUT, USBEV_RES_CRC, 8'hC0, 8'h01, 8'h81, 8'h08, 8'h00, 2'b01},
		{4'h2, USBEV_TOK_IN, USBEV_RES_ACK, 8'hC0, 8'h01, 8'h31, 8'h00, 8'h00, 2'b01},
		{4'h7, USBEV_TOK_IN, USBEV_RES_ACK, 8'h90, 8'h00, 8'h39, 8'h00, 8'h00, 2'b01},
		{4'h4, USBEV_TOK_OUT, USBEV_RES_ACK, 8'h80, 8'h02, 8'h02, 8'h00, 8'h00, 2'b11},
		{4'h6, USBEV_TOK_OUT, USBEV_RES_ACK, 8'h00, 8'h5A, 8'h5A, 8'h00, 8'h00, 2'b00}};
	localparam logic [7:0] OFS [9] = '{8'h06, 8'h07, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h3A, 8'h3B, 8'h20};

	usbev_core #(.IDLE_CYCLES(50)) DUT (
		.core_clk(core_clk), .rst_n(rst_n), .ioAddr(ioAddr), .ioWrite(ioWrite), .ioRead(ioRead),
		.ioWdata(ioWdata), .ioRdata(ioRdata), .lineIdle(lineIdle), .lineSe0Reset(lineSe0Reset),
		.sofSeen(sofSeen), .fifoPending(fifoPending), .trnValid(trnValid), .trnToken(trnToken),
		.trnResult(trnResult), .trnEpAddr(trnEpAddr), .endpointTablePointer(16'h0040),
		.sramRead(sramRead), .sramWrite(sramWrite), .sramAddr(sramAddr), .sramWdata(sramWdata),
		.sramRdata(sramRdata), .sramAck(sramAck), .epReplyValid(epReplyValid),
		.epReplyNak(epReplyNak), .epDataPid(epDataPid), .epMultiPacket(epMultiPacket),
		.busIrq(busIrq), .transferIrq(transferIrq), .irqPriorityLevel(irqPriorityLevel),
		.padTrim(padTrim), .suspended(suspended));
	usbev_sram_model SRAM (.core_clk(core_clk), .slow(slow), .sramRead(sramRead),
		.sramWrite(sramWrite), .sramAddr(sramAddr), .sramWdata(sramWdata),
		.sramRdata(sramRdata), .sramAck(sramAck));

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// ****
	// access tasks
	// ****
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc
	task automatic io_wr(input logic [7:0] a, input logic [7:0] d, input logic sof = 1'b0);
		@(posedge core_clk);
		ioAddr <= a;
		ioWdata <= d;
		ioWrite <= 1'b1;
		sofSeen <= sof;
		@(posedge core_clk);
		ioWrite <= 1'b0;
		sofSeen <= 1'b0;
	endtask : io_wr
	task automatic io_rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk);
		ioAddr <= a;
		ioRead <= 1'b1;
		@(posedge core_clk);
		ioRead <= 1'b0;
		#1;
		`CHK(ioRdata, e)
	endtask : io_rd
	// the wait bound doubles as the no-reply window of a disabled endpoint
	task automatic ep_trn(input logic [3:0] ep, input logic [1:0] tk, input logic [1:0] rs);
		@(posedge core_clk);
		trnEpAddr <= ep;
		trnToken <= tk;
		trnResult <= rs;
		trnValid <= 1'b1;
		@(posedge core_clk);
		trnValid <= 1'b0;
		seen = 1'b0;
		for (int i = 0; i < 40 && !seen; i++) begin
			#1;
			if (epReplyValid === 1'b1) seen = 1'b1;
			else @(posedge core_clk);
		end
	endtask : ep_trn
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, nMismatch);
		if (nMismatch == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : complete_run
	// ****
	// main sequence
	// ****
	initial begin
		{rst_n, ioWrite, ioRead, lineIdle, lineSe0Reset, sofSeen, fifoPending, trnValid, slow} = '0;
		{ioAddr, ioWdata, trnToken, trnResult, trnEpAddr} = '0;
		nMismatch = 0;
		comparisons = 0;
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 9; i++) io_rd(OFS[i], 8'h00);
		io_wr(8'h0B, 8'hA5);
		io_rd(8'h0A, 8'hA5);
		io_wr(8'h0A, 8'h00);
		io_rd(8'h0B, 8'hA5);
		io_wr(8'h0A, 8'h85);
		io_rd(8'h0A, 8'h20);
		io_wr(8'h0D, 8'hFF);
		io_rd(8'h0C, 8'h03);
		io_wr(8'h0C, 8'h01);
		io_rd(8'h0D, 8'h02);
		io_wr(8'h0A, 8'hFF);
		io_wr(8'h0C, 8'hFF);
		io_wr(8'h20, 8'hFF, 1'b1);
		io_rd(8'h0B, 8'h80);
		io_wr(8'h0A, 8'h80, 1'b1);
		io_rd(8'h0A, 8'h80);
		io_wr(8'h0A, 8'hFF);
		io_wr(8'h3A, 8'h5C);
		io_wr(8'h3B, 8'hA3);
		io_rd(8'h3B, 8'hA3);
		`CHK(padTrim, 16'hA35C)
		lineSe0Reset <= 1'b1;
		cyc(6);
		@(posedge core_clk);
		lineSe0Reset <= 1'b0;
		io_rd(8'h0A, 8'h10);
		io_wr(8'h0A, 8'hFF);
		lineIdle <= 1'b1;
		cyc(40);
		io_rd(8'h0A, 8'h00);
		cyc(30);
		io_rd(8'h0A, 8'h40);
		`CHK(suspended, 1'b1)
		io_wr(8'h0A, 8'hFF);
		lineIdle <= 1'b0;
		cyc(8);
		io_rd(8'h0A, 8'h20);
		io_wr(8'h0A, 8'hFF);
		io_wr(8'h07, 8'h02);
		fifoPending <= 1'b1;
		io_rd(8'h0C, 8'h02);
		`CHK(transferIrq, 1'b0)
		io_wr(8'h06, 8'h02);
		cyc(2);
		`CHK(transferIrq, 1'b1)
		`CHK(irqPriorityLevel, 2'b10)
		io_wr(8'h07, 8'h01);
		cyc(2);
		`CHK(transferIrq, 1'b0)
		io_wr(8'h0D, 8'h01);
		cyc(2);
		`CHK(transferIrq, 1'b1)
		io_wr(8'h06, 8'h81);
		io_wr(8'h0B, 8'h80);
		cyc(2);
		`CHK(busIrq, 1'b1)
		io_wr(8'h06, 8'h80);
		cyc(2);
		`CHK({busIrq, transferIrq}, 2'b00)
		fifoPending <= 1'b0;
		for (int i = 0; i < 10; i++) begin
			r = ROWS[i];
			io_wr(8'h0A, 8'hFF);
			io_wr(8'h0C, 8'hFF);
			slow <= i[0];
			base = 8'h40 + {r[49:46], 4'h0} + ((r[45:44] == USBEV_TOK_IN) ? 8'h08 : 8'h00);
			SRAM.mem[base] = r[41:34];
			SRAM.mem[base + 8'h01] = r[33:26];
			ep_trn(r[49:46], r[45:44], r[43:42]);
			`CHK(seen, r[0])
			if (seen) `CHK(epReplyNak, r[1])
			if (seen) `CHK(epMultiPacket, r[39])
			if (seen && r[41:40] == 2'b11 && r[45:44] == USBEV_TOK_IN) `CHK(epDataPid, 1'b0)
			if (!r[1]) `CHK(SRAM.mem[base + 8'h01], r[25:18])
			if (!r[1]) io_rd(8'h0A, r[17:10]);
			if (!r[1]) io_rd(8'h0C, r[9:2]);
		end
		complete_run();
	end
endmodule : tb
